/* File: spcd_pkg.sv */
/*
  Constants for the serial programming command decoder: opcodes, field
  positions, reset values, link timing and the host register map.
  Assumes a 50 MHz host clock and a link clock of 160 ns period.
*/
package spcd_pkg;

  // ----------------------------------------------------------------
  // Instruction format
  // ----------------------------------------------------------------
  localparam logic [4:0] READ_LOAD_BIT = 5'h17;
  localparam logic [4:0] FIRST_RD_BIT = 5'h18;
  localparam logic [4:0] LAST_BIT = 5'h1f;
  localparam logic [7:0] OP_PREFIX = 8'hac;
  localparam logic [7:0] OP_PROG_EN = 8'h53;
  localparam logic [2:0] OP_ERASE_TOP = 3'h4;
  localparam logic [4:0] OP_LOCK_TOP = 5'h1f;
  localparam logic [6:0] OP_FUSE_TOP = 7'h5f;
  localparam logic [3:0] OP_RD_PM = 4'h2;
  localparam logic [3:0] OP_WR_PM = 4'h4;
  localparam logic [2:0] OP_PM_LOW = 3'h0;
  localparam logic [7:0] OP_RD_EE = 8'ha0;
  localparam logic [7:0] OP_WR_EE = 8'hc0;
  localparam logic [7:0] OP_RD_LF = 8'h58;
  localparam logic [7:0] OP_RD_SIG = 8'h30;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] BLANK_BYTE = 8'hff;
  localparam logic [15:0] BLANK_WORD = 16'hffff;
  localparam int PM_HI_POS = 3;
  localparam int PM_WORDS = 1024;
  localparam int EE_BYTES = 128;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0] LOCK_RESET = 2'h3;
  localparam logic FUSE_RESET = 1'b0;
  localparam logic SYNC_RST_HIGH = 1'b1;
  localparam logic SYNC_RST_LOW = 1'b0;

  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCK_PERIOD_NS = 160;
  localparam int HALF_CYC = (SCK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] HALF_LAST = 3'(HALF_CYC - 1);
  localparam logic [1:0] SYNC_PULSES = 2'h2;

  // ----------------------------------------------------------------
  // Host register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_INSTR = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RESULT = 4'hc;
  localparam int CTRL_SESSION_POS = 0;
  localparam int CTRL_GO_POS = 1;
  localparam int STAT_DONE_POS = 1;

  typedef enum logic [1:0] {
    HS_FREE = 2'b00,
    HS_ENTER = 2'b01,
    HS_READY = 2'b10,
    HS_SHIFT = 2'b11
  } spcd_hstate_t;

  // Byte n of an instruction, n = 0 is the first byte on the wire
  function automatic logic [7:0] spcd_byte(input logic [31:0] w, input logic [1:0] n);
    case (n)
      2'h0: return w[31:24];
      2'h1: return w[23:16];
      2'h2: return w[15:8];
      default: return w[7:0];
    endcase
  endfunction : spcd_byte

endpackage : spcd_pkg

/* File: spcd_link_if.sv */
/*
  Serial programming link between programmer and device.
  Assumes the host drives sck, target reset and mosi; the device drives miso.
*/
`timescale 1ns/10ps
interface spcd_link_if;
  logic sck;
  logic tgt_rstn;
  logic mosi;
  logic miso;

  modport dev (input sck, input tgt_rstn, input mosi, output miso);
  modport host (output sck, output tgt_rstn, output mosi, input miso);
endinterface : spcd_link_if

/* File: spcd_sync.sv */
/*
  Two-stage level synchroniser.
  Assumes d_in is a level from another clock domain.
*/
`timescale 1ns/10ps
module spcd_sync #(
  parameter logic RESET_VAL = 1'b0 // Level shown during reset
)
(
  input wire logic clk_in,  // Destination clock
  input wire logic rstn_in, // Synchronous reset, active low
  input wire logic d_in,    // Asynchronous level
  output logic q_out        // Synchronised level
);
  logic meta_q;

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      meta_q <= RESET_VAL;
      q_out <= RESET_VAL;
    end
    else
    begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule : spcd_sync

/* File: spcd_device.sv */
/*
  Device end of the serial programming link: shifts in four-byte
  instructions, executes them and returns read data on miso.
  Assumes the host clocks the link, sets mosi before each rising edge,
  and gives two sck pulses after lowering target reset before the
  first instruction bit.
*/
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
module spcd_device
  import spcd_pkg::*;
#(
  parameter bit FIVE_PIN = 1'b0,          // 1 = internal oscillator variant
  parameter bit SERIAL_PROG_ENABLE_FUSE = 1'b0, // 0 = serial programming allowed
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE1 = 8'h3c, // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE2 = 8'h0f  // Arbitrary identity value
)
(
  spcd_link_if.dev link,                  // Serial link, clocked by sck
  input wire logic rstn_in,               // Power-on reset, sync to sck
  input wire logic nv_init_n_in,          // Blank lock and fuse cells
  output logic prog_enabled_out,          // Programming enabled
  output logic [1:0] lock_bits_out,       // {lock 2, lock 1}, 0 = programmed
  output logic fast_startup_fuse_out,     // Active startup fuse
  output logic internal_osc_select_fuse_out // Active oscillator fuse
);
  logic tgt_rstn_s;
  logic rstn_s;
  logic nv_init_n_s;
  logic in_prog;
  logic [4:0] bit_cnt_q;
  logic [30:0] shift_q;
  logic [7:0] out_q;
  logic miso_q;
  logic prog_en_q;
  logic [1:0] lock_q;
  logic fuse_nv_q;
  logic fuse_act_q;
  logic mode3;
  logic lock1_free;
  logic [15:0] pm_mem [PM_WORDS];
  logic [7:0] ee_mem [EE_BYTES];
  logic [31:0] hdr_w;
  logic [7:0] rd_b1;
  logic [7:0] rd_b2;
  logic [7:0] rd_b3;
  logic [15:0] rd_pm;
  logic [7:0] rd_sig;
  logic [7:0] rd_res;
  logic [31:0] ex_w;
  logic [7:0] ex_b1;
  logic [7:0] ex_b2;
  logic [7:0] ex_b3;
  logic [7:0] ex_b4;
  logic last_bit;
  logic do_en;
  logic do_erase;
  logic do_lock;
  logic do_fuse;
  logic do_pm_wr;
  logic do_ee_wr;

  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  // Reset pins come from outside the link clock and are retimed first
  spcd_sync #(
    .RESET_VAL(SYNC_RST_LOW)
  ) u_rstn_sync (
    .clk_in(link.sck),
    .rstn_in(SYNC_RST_HIGH),
    .d_in(rstn_in),
    .q_out(rstn_s)
  );

  spcd_sync #(
    .RESET_VAL(SYNC_RST_LOW)
  ) u_nv_sync (
    .clk_in(link.sck),
    .rstn_in(SYNC_RST_HIGH),
    .d_in(nv_init_n_in),
    .q_out(nv_init_n_s)
  );

  spcd_sync #(
    .RESET_VAL(SYNC_RST_HIGH)
  ) u_rst_sync (
    .clk_in(link.sck),
    .rstn_in(rstn_s),
    .d_in(link.tgt_rstn),
    .q_out(tgt_rstn_s)
  );

  assign in_prog = !tgt_rstn_s;

  // Counter wraps every 32 bits, so instructions follow back to back
  always_ff @(posedge link.sck)
  begin
    if (!rstn_s || tgt_rstn_s)
      bit_cnt_q <= 5'h00;
    else
      bit_cnt_q <= bit_cnt_q + 5'h01;
  end

  always_ff @(posedge link.sck)
  begin
    if (!rstn_s)
      shift_q <= 31'h0;
    else
      shift_q <= {shift_q[29:0], link.mosi};
  end

  // ----------------------------------------------------------------
  // Read path, looked up once three bytes are in
  // ----------------------------------------------------------------
  assign mode3 = (lock_q == 2'h0);
  assign lock1_free = lock_q[0];
  assign hdr_w = {shift_q[22:0], link.mosi, ZERO_BYTE};

  always_comb
  begin
    rd_b1 = spcd_byte(hdr_w, 2'h0);
    rd_b2 = spcd_byte(hdr_w, 2'h1);
    rd_b3 = spcd_byte(hdr_w, 2'h2);
    rd_pm = pm_mem[{rd_b2[1:0], rd_b3}];
    case (rd_b3[1:0])
      2'h0: rd_sig = SIG_BYTE0;
      2'h1: rd_sig = SIG_BYTE1;
      2'h2: rd_sig = SIG_BYTE2;
      default: rd_sig = BLANK_BYTE;
    endcase
    rd_res = ZERO_BYTE;
    if (prog_en_q)
    begin
      if (rd_b1[7:4] == OP_RD_PM && rd_b1[2:0] == OP_PM_LOW)
        rd_res = mode3 ? BLANK_BYTE : (rd_b1[PM_HI_POS] ? rd_pm[15:8] : rd_pm[7:0]);
      else if (rd_b1 == OP_RD_EE && rd_b2 == ZERO_BYTE)
        rd_res = mode3 ? BLANK_BYTE : ee_mem[rd_b3[6:0]];
      else if (rd_b1 == OP_RD_LF)
        rd_res = {lock_q[0], lock_q[1], SERIAL_PROG_ENABLE_FUSE, 4'hf, fuse_nv_q};
      else if (rd_b1 == OP_RD_SIG)
        rd_res = mode3 ? BLANK_BYTE : rd_sig;
      else
        rd_res = ZERO_BYTE;
    end
  end

  // Result leaves MSB first, one bit per rising edge, starting at the last rising edge of byte three
  always_ff @(posedge link.sck)
  begin
    if (!rstn_s)
    begin
      miso_q <= 1'b0;
      out_q <= ZERO_BYTE;
    end
    else if (in_prog && bit_cnt_q == READ_LOAD_BIT)
    begin
      miso_q <= rd_res[7];
      out_q <= {rd_res[6:0], 1'b0};
    end
    else
    begin
      miso_q <= out_q[7];
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  assign link.miso = miso_q;

  // ----------------------------------------------------------------
  // Execution after the last bit
  // ----------------------------------------------------------------
  assign ex_w = {shift_q, link.mosi};
  assign ex_b1 = spcd_byte(ex_w, 2'h0);
  assign ex_b2 = spcd_byte(ex_w, 2'h1);
  assign ex_b3 = spcd_byte(ex_w, 2'h2);
  assign ex_b4 = spcd_byte(ex_w, 2'h3);
  assign last_bit = in_prog && bit_cnt_q == LAST_BIT;
  assign do_en = last_bit && ex_b1 == OP_PREFIX && ex_b2 == OP_PROG_EN
    && !SERIAL_PROG_ENABLE_FUSE;
  assign do_erase = last_bit && prog_en_q && ex_b1 == OP_PREFIX
    && ex_b2[7:5] == OP_ERASE_TOP;
  assign do_lock = last_bit && prog_en_q && ex_b1 == OP_PREFIX
    && ex_b2[7:3] == OP_LOCK_TOP && ex_b2[0];
  assign do_fuse = last_bit && prog_en_q && ex_b1 == OP_PREFIX
    && ex_b2[7:1] == OP_FUSE_TOP;
  assign do_pm_wr = last_bit && prog_en_q && lock1_free
    && ex_b1[7:4] == OP_WR_PM && ex_b1[2:0] == OP_PM_LOW;
  assign do_ee_wr = last_bit && prog_en_q && lock1_free
    && ex_b1 == OP_WR_EE && ex_b2 == ZERO_BYTE;

  // Enable is lost as soon as target reset is seen high
  always_ff @(posedge link.sck)
  begin
    if (!rstn_s || tgt_rstn_s)
      prog_en_q <= 1'b0;
    else if (do_en)
      prog_en_q <= 1'b1;
  end

  // Arrays have no reset: they stand for nonvolatile storage
  always_ff @(posedge link.sck)
  begin
    if (do_erase)
    begin
      for (int i = 0; i < PM_WORDS; i++)
        pm_mem[i] <= BLANK_WORD;
      for (int j = 0; j < EE_BYTES; j++)
        ee_mem[j] <= BLANK_BYTE;
    end
    else
    begin
      if (do_pm_wr && ex_b1[PM_HI_POS])
        pm_mem[{ex_b2[1:0], ex_b3}][15:8] <= ex_b4;
      else if (do_pm_wr)
        pm_mem[{ex_b2[1:0], ex_b3}][7:0] <= ex_b4;
      if (do_ee_wr)
        ee_mem[ex_b3[6:0]] <= ex_b4;
    end
  end

  // Lock and fuse cells survive power-on reset; blanking clears both, chip erase clears the lock bits only
  always_ff @(posedge link.sck)
  begin
    if (!nv_init_n_s)
    begin
      lock_q <= LOCK_RESET;
      fuse_nv_q <= FUSE_RESET;
    end
    else
    begin
      if (do_erase)
        lock_q <= LOCK_RESET;
      else if (do_lock)
        lock_q <= lock_q & ex_b2[2:1];
      if (do_fuse)
        fuse_nv_q <= ex_b2[0];
    end
  end

  // The active fuse copy is only refreshed by power-on reset
  always_ff @(posedge link.sck)
  begin
    if (!rstn_s)
      fuse_act_q <= fuse_nv_q;
  end

  assign prog_enabled_out = prog_en_q;
  assign lock_bits_out = lock_q;
  assign fast_startup_fuse_out = FIVE_PIN ? 1'b1 : fuse_act_q;
  assign internal_osc_select_fuse_out = FIVE_PIN ? fuse_act_q : 1'b1;
endmodule : spcd_device

/* File: spcd_host.sv */
/*
  Programmer end of the serial programming link: a register port takes
  a four-byte instruction, the link shifts it out and captures byte four.
  Assumes a 50 MHz clock; the link clock is divided down from it.
*/
`timescale 1ns/10ps
module spcd_host
  import spcd_pkg::*;
(
  input wire logic clock_in,        // 50 MHz clock
  input wire logic rstn_in,         // Synchronous reset, active low
  input wire logic [3:0] addr_in,   // Register byte address
  input wire logic [31:0] wdata_in, // Write data
  input wire logic wr_in,           // Write strobe
  input wire logic rd_in,           // Read strobe
  output logic [31:0] rdata_out,    // Read data, cycle after rd_in
  spcd_link_if.host link            // Serial link
);
  spcd_hstate_t st_q;
  logic [2:0] div_q;
  logic tick;
  logic sck_q;
  logic tgt_rstn_q;
  logic [1:0] pre_q;
  logic [4:0] bit_q;
  logic [31:0] tx_q;
  logic [7:0] rx_q;
  logic miso_s;
  logic [31:0] instr_q;
  logic session_q;
  logic go_pend_q;
  logic done_q;
  logic [7:0] result_q;
  logic busy;
  logic start_shift;
  logic shift_tick;
  logic finish;

  // ----------------------------------------------------------------
  // Link clock and sequencing
  // ----------------------------------------------------------------
  assign tick = (div_q == HALF_LAST);
  assign busy = go_pend_q || st_q == HS_SHIFT;
  assign start_shift = tick && st_q == HS_READY && session_q && go_pend_q;
  assign shift_tick = tick && st_q == HS_SHIFT;
  assign finish = shift_tick && sck_q && bit_q == LAST_BIT;

  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || tick)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  // sck runs free while the target runs, and is gated during programming
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      st_q <= HS_FREE;
      sck_q <= 1'b0;
      tgt_rstn_q <= 1'b1;
      pre_q <= 2'h0;
      bit_q <= 5'h00;
    end
    else if (tick)
    begin
      case (st_q)
        HS_FREE:
        begin
          sck_q <= !sck_q;
          if (session_q && sck_q)
          begin
            tgt_rstn_q <= 1'b0;
            pre_q <= 2'h0;
            st_q <= HS_ENTER;
          end
        end
        HS_ENTER:
        begin
          sck_q <= !sck_q;
          if (!sck_q)
            pre_q <= pre_q + 2'h1;
          else if (pre_q == SYNC_PULSES)
            st_q <= HS_READY;
        end
        HS_READY:
        begin
          if (!session_q)
          begin
            tgt_rstn_q <= 1'b1;
            st_q <= HS_FREE;
          end
          else if (go_pend_q)
          begin
            bit_q <= 5'h00;
            st_q <= HS_SHIFT;
          end
        end
        HS_SHIFT:
        begin
          sck_q <= !sck_q;
          if (sck_q && bit_q == LAST_BIT)
            st_q <= HS_READY;
          else if (sck_q)
            bit_q <= bit_q + 5'h01;
        end
        default:
          st_q <= HS_FREE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shifters
  // ----------------------------------------------------------------
  spcd_sync #(
    .RESET_VAL(SYNC_RST_LOW)
  ) u_miso_sync (
    .clk_in(clock_in),
    .rstn_in(rstn_in),
    .d_in(link.miso),
    .q_out(miso_s)
  );

  // mosi changes on the falling half, half a period before the rise
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || finish)
      tx_q <= 32'h0;
    else if (start_shift)
      tx_q <= instr_q;
    else if (shift_tick && sck_q)
      tx_q <= {tx_q[30:0], 1'b0};
  end

  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || start_shift)
      rx_q <= ZERO_BYTE;
    else if (shift_tick && !sck_q && bit_q >= FIRST_RD_BIT)
      rx_q <= {rx_q[6:0], miso_s};
  end

  assign link.sck = sck_q;
  assign link.tgt_rstn = tgt_rstn_q;
  assign link.mosi = tx_q[31];

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      instr_q <= 32'h0;
      session_q <= 1'b0;
      go_pend_q <= 1'b0;
      result_q <= ZERO_BYTE;
    end
    else
    begin
      if (wr_in && addr_in == REG_INSTR && !busy)
        instr_q <= wdata_in;
      if (wr_in && addr_in == REG_CTRL)
        session_q <= wdata_in[CTRL_SESSION_POS];
      if (start_shift || !session_q)
        go_pend_q <= 1'b0;
      else if (wr_in && addr_in == REG_CTRL && wdata_in[CTRL_GO_POS])
        go_pend_q <= 1'b1;
      if (finish)
        result_q <= rx_q;
    end
  end

  // Completion wins over a clear written in the same cycle
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
      done_q <= 1'b0;
    else if (finish)
      done_q <= 1'b1;
    else if (wr_in && addr_in == REG_STATUS && wdata_in[STAT_DONE_POS])
      done_q <= 1'b0;
  end

  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || !rd_in)
      rdata_out <= 32'h0;
    else
    begin
      case (addr_in)
        REG_INSTR: rdata_out <= instr_q;
        REG_CTRL: rdata_out <= {31'h0, session_q};
        REG_STATUS: rdata_out <= {29'h0, st_q == HS_READY || st_q == HS_SHIFT, done_q, busy};
        REG_RESULT: rdata_out <= {24'h0, result_q};
        default: rdata_out <= 32'h0;
      endcase
    end
  end
endmodule : spcd_host

/* File: spcd_checker.sv */
/*
  Checker for the serial programming link wires, sampled on the host clock.
  Assumes sck is divided from clock_in and changes only at its edges.
*/
`timescale 1ns/10ps
module spcd_checker
  import spcd_pkg::*;
(
  input wire logic clock_in, // Host clock
  input wire logic rstn_in,  // Host reset, active low
  input wire logic sck,      // Link clock
  input wire logic tgt_rstn, // Target reset, active low
  input wire logic mosi,     // Host to device data
  input wire logic miso      // Device to host data
);
  logic sck_q;
  logic rise;
  logic [1:0] pre_q;
  logic [4:0] bits_q;
  logic [6:0] sh_q;
  logic [7:0] op_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  // ----------------------------------------------------------------
  // Bit position within the instruction
  // ----------------------------------------------------------------
  assign rise = sck && !sck_q;

  always_ff @(posedge clock_in)
  begin
    sck_q <= rstn_in ? sck : 1'b0;
  end

  // Preamble rises are not instruction bits
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || tgt_rstn)
    begin
      pre_q <= 2'h0;
      bits_q <= 5'h0;
    end
    else if (rise && pre_q != SYNC_PULSES)
    begin
      pre_q <= pre_q + 2'h1;
    end
    else if (rise)
    begin
      bits_q <= bits_q + 5'h1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      sh_q <= 7'h0;
      op_q <= 8'h0;
    end
    else if (rise && pre_q == SYNC_PULSES)
    begin
      sh_q <= {sh_q[5:0], mosi};
      if (bits_q == 5'h7)
        op_q <= {sh_q, mosi};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sck_high_len_a:
    assert property ($rose(sck) |=> sck [*3] ##1 !sck)
    else $error("link clock high phase has wrong length");
  sck_low_len_a:
    assert property (($fell(sck) && tgt_rstn) |=> !sck [*3] ##1 sck)
    else $error("free link clock low phase has wrong length");
  mosi_setup_a:
    assert property ($changed(mosi) |-> !sck)
    else $error("mosi changed while link clock high");
  miso_launch_a:
    assert property ($changed(miso) |-> $rose(sck))
    else $error("miso changed away from a link clock rise");
  rstn_edge_a:
    assert property ($changed(tgt_rstn) |-> !sck)
    else $error("target reset moved while link clock high");
  miso_quiet_a:
    assert property ((bits_q >= 5'h1 && bits_q <= 5'h17 && !$rose(sck)) |-> !miso)
    else $error("miso active before byte four");
  write_quiet_a:
    assert property ((bits_q >= 5'h8 && (op_q == OP_PREFIX || op_q == OP_WR_EE
      || op_q[7:4] == OP_WR_PM)) |-> !miso)
    else $error("miso active during a write instruction");
  lockfuse_bit5_a:
    assert property ((op_q == OP_RD_LF && bits_q == 5'h1a && !$rose(sck)) |-> !miso)
    else $error("enable fuse bit of lock read not programmed");
endmodule : spcd_checker

/* File: test_serial_prog_cmd_decoder.sv */
/*
  Testbench: host and device joined by the link, driven over the host port.
  Assumes the device keeps its default enable fuse and three-pin variant.
*/
`timescale 1ns/10ps
module test_serial_prog_cmd_decoder;
  import spcd_pkg::*;
  localparam logic [7:0] SIG0 = 8'h6b; // Arbitrary value
  localparam logic [7:0] SIG1 = 8'h2d; // Arbitrary value
  localparam logic [7:0] SIG2 = 8'h71; // Arbitrary value
  logic clock_in = 1'b0;
  logic host_rstn = 1'b0;
  logic dev_rstn = 1'b0;
  logic nv_init_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic prog_en;
  logic [1:0] lock_bits;
  logic fast_fuse;
  logic osc_sel;
  logic [7:0] sigs [4];
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 32'h12b4ed5b;

  always #10 clock_in = ~clock_in;

  spcd_link_if spcd_link_if_inst ();
  spcd_host spcd_host_inst (.clock_in(clock_in), .rstn_in(host_rstn), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr_en), .rd_in(rd_en), .rdata_out(rdata),
    .link(spcd_link_if_inst.host));
  spcd_device #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2)) spcd_device_inst (
    .link(spcd_link_if_inst.dev), .rstn_in(dev_rstn), .nv_init_n_in(nv_init_n),
    .prog_enabled_out(prog_en), .lock_bits_out(lock_bits), .fast_startup_fuse_out(fast_fuse),
    .internal_osc_select_fuse_out(osc_sel));
  spcd_checker spcd_checker_inst (.clock_in(clock_in), .rstn_in(host_rstn),
    .sck(spcd_link_if_inst.sck), .tgt_rstn(spcd_link_if_inst.tgt_rstn),
    .mosi(spcd_link_if_inst.mosi), .miso(spcd_link_if_inst.miso));

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic print_verdict;
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock_in);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock_in);
    rd_en <= 1'b0;
    @(negedge clock_in);
    d = rdata;
  endtask : rd

  // Bounded poll of one status bit
  task automatic wait_stat(input int pos, input logic val);
    logic [31:0] s;
    for (int i = 0; i < 600; i++)
    begin
      rd(REG_STATUS, s);
      if (s[pos] === val)
        return;
    end
    num_errors++;
    print_verdict();
  endtask : wait_stat

  task automatic exec(input logic [31:0] ins, output logic [7:0] res);
    logic [31:0] r;
    wr(REG_INSTR, ins);
    wr(REG_CTRL, 32'h3);
    wait_stat(STAT_DONE_POS, 1'b1);
    wr(REG_STATUS, 32'h2);
    rd(REG_STATUS, r);
    chk(r, 32'h4);
    rd(REG_RESULT, r);
    res = r[7:0];
  endtask : exec

  task automatic ask(input logic [31:0] ins, input logic [7:0] exp);
    logic [7:0] r;
    exec(ins, r);
    chk({24'h0, r}, {24'h0, exp});
  endtask : ask

  function automatic logic [31:0] pm(input logic w, input logic h, input logic [9:0] a,
    input logic [7:0] d);
    return {w ? OP_WR_PM : OP_RD_PM, h, OP_PM_LOW, 6'h0, a, d};
  endfunction : pm

  function automatic logic [31:0] ee(input logic w, input logic [7:0] a, input logic [7:0] d);
    return {w ? OP_WR_EE : OP_RD_EE, ZERO_BYTE, a, d};
  endfunction : ee

  // Lock 1 at bit 7, lock 2 at bit 6, enable fuse programmed, unused bits high
  function automatic logic [7:0] lf_exp(input logic [1:0] lk, input logic f);
    return {lk[0], lk[1], 1'b0, 4'hf, f};
  endfunction : lf_exp

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic [7:0] r8;
    logic [7:0] d;
    logic [7:0] d2;
    logic [7:0] a;
    logic [9:0] pa;
    sigs = '{SIG0, SIG1, SIG2, BLANK_BYTE};
    repeat (2) @(posedge clock_in);
    host_rstn <= 1'b1;
    // Device reset needs free-running link clock rises
    repeat (40) @(posedge clock_in);
    dev_rstn <= 1'b1;
    nv_init_n <= 1'b1;
    repeat (20) @(posedge clock_in);
    rd(4'h2, r);
    chk(r, 32'h0);
    wr(REG_CTRL, 32'h1);
    wait_stat(2, 1'b1);
    ask(ee(1'b0, 8'h05, 8'h00), ZERO_BYTE);
    exec({OP_PREFIX, OP_PROG_EN, 16'h0}, r8);
    chk({31'h0, prog_en}, 32'h1);
    d = 8'($random(seed));
    exec({OP_PREFIX, 3'h4, d[4:0], 16'($random(seed))}, r8);
    ask(pm(1'b0, 1'b1, 10'h2a5, 8'h0), BLANK_BYTE);
    ask(ee(1'b0, 8'h33, 8'h0), BLANK_BYTE);
    for (int i = 0; i < 6; i++)
    begin
      a = (i == 0) ? 8'h7f : 8'($random(seed));
      pa = (i == 0) ? 10'h3ff : 10'($random(seed));
      d = 8'($random(seed));
      d2 = 8'($random(seed));
      exec(ee(1'b1, {1'b0, a[6:0]}, d), r8);
      ask(ee(1'b0, {1'b1, a[6:0]}, 8'h0), d);
      exec(pm(1'b1, 1'b0, pa, d), r8);
      exec(pm(1'b1, 1'b1, pa, d2), r8);
      ask(pm(1'b0, 1'b0, pa, 8'h0), d);
      ask(pm(1'b0, 1'b1, pa, 8'h0), d2);
    end
    ask({OP_RD_LF, 24'h0}, lf_exp(LOCK_RESET, FUSE_RESET));
    exec({OP_PREFIX, 8'hbf, 16'h0}, r8);
    ask({OP_RD_LF, 24'h0}, lf_exp(LOCK_RESET, 1'b1));
    chk({31'h0, fast_fuse}, {31'h0, FUSE_RESET});
    chk({31'h0, osc_sel}, 32'h1);
    for (int b = 0; b < 4; b++)
      ask({OP_RD_SIG, 8'h0, 6'h0, 2'(b), 8'h0}, sigs[b]);
    exec(ee(1'b1, 8'h7e, 8'ha5), r8);
    exec({OP_PREFIX, 8'hfd, 16'h0}, r8);
    chk({30'h0, lock_bits}, 32'h2);
    exec(ee(1'b1, 8'h7e, 8'h11), r8);
    ask(ee(1'b0, 8'h7e, 8'h0), 8'ha5);
    exec({OP_PREFIX, 8'hfb, 16'h0}, r8);
    ask({OP_RD_LF, 24'h0}, lf_exp(2'h0, 1'b1));
    ask({OP_RD_SIG, 16'h0, 8'h0}, BLANK_BYTE);
    exec({OP_PREFIX, 8'h9c, 16'h0}, r8);
    chk({30'h0, lock_bits}, 32'h3);
    wr(REG_CTRL, 32'h0);
    wait_stat(2, 1'b0);
    @(posedge clock_in);
    dev_rstn <= 1'b0;
    repeat (40) @(posedge clock_in);
    dev_rstn <= 1'b1;
    repeat (40) @(posedge clock_in);
    chk({31'h0, fast_fuse}, 32'h1);
    chk({31'h0, prog_en}, 32'h0);
    print_verdict();
  end
endmodule : test_serial_prog_cmd_decoder
